// ==== ladder_pkg.sv ====
// package: register map, field layout, reset values and timing constants for the ladder block
package ladder_pkg;
  localparam int unsigned ADDR_W = 4;
  // register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_REF = 4'h4;
  localparam logic [3:0] OFF_TIMING = 4'h8;
  localparam logic [3:0] OFF_SEGEN = 4'hc;
  // control register fields
  localparam int unsigned CTRL_MUX_LSB = 0;
  localparam int unsigned CTRL_WFT_BIT = 2;
  localparam int unsigned CTRL_ACT_BIT = 3;
  // reference control fields
  localparam int unsigned REF_EN_BIT = 0;
  localparam int unsigned REF_SRC_BIT = 1;
  localparam int unsigned REF_TIE_BIT = 2;
  localparam int unsigned REF_PIN_LSB = 3;
  localparam int unsigned REF_CST_LSB = 6;
  // timing register fields
  localparam int unsigned TIM_AT_LSB = 0;
  localparam int unsigned TIM_BP_LSB = 4;
  localparam int unsigned TIM_AP_LSB = 6;
  // reset values and write masks
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] REF_RST = 32'h0000_0000;
  localparam logic [31:0] TIM_RST = 32'h0000_0000;
  localparam logic [31:0] SEGEN_RST = 32'h0000_0000;
  localparam logic [31:0] TIM_MASK = 32'h0000_00f7;
  localparam logic [31:0] REF_MASK = 32'h0000_01ff;
  localparam logic [31:0] CTRL_MASK = 32'h0000_000f;
  // slot lengths in 32 kHz clocks per waveform type
  localparam logic [4:0] SLOT_TYPE_A = 5'h0f;
  localparam logic [4:0] SLOT_TYPE_B = 5'h1f;
  // power codes
  localparam logic [1:0] PWR_OFF = 2'h0;
  localparam logic [1:0] PWR_LOW = 2'h1;
  localparam logic [1:0] PWR_MED = 2'h2;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_A = 2'b01,
    PH_B = 2'b11
  } phase_t;
endpackage

// ==== tick_sync.sv ====
// three-stage synchroniser and rising-edge pulse for the 32 kHz clock pin
`timescale 1ns/1ps
module tick_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic rise_o
);
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic level_r;
  logic level_nxt;
  logic rise_nxt;

  // first stage feeds only the second; a change counts once stages two and three agree
  always_comb begin
    sync_nxt = {sync_r[1:0], async_i};
    level_nxt = level_r;
    if (sync_r[1] == sync_r[2]) begin
      level_nxt = sync_r[2];
    end
    rise_nxt = level_nxt & ~level_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r <= 3'h0;
      level_r <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      level_r <= level_nxt;
      rise_o <= rise_nxt;
    end
  end
endmodule // tick_sync

// ==== ladder_pin_ctrl.sv ====
// top: bias ladder power sequencing, reference gating and segment/common pin control
`timescale 1ns/1ps
// How it works
// R1: A-interval code sets clocks in mode A
// R2: type A: B fills rest of 15
// R3: type B: B fills rest of 31
// R4: timing bit 3 always reads zero
// R5: contrast field picks one of eight taps
// R6: inactive module opens contrast ladder
// R7: inactive module turns internal reference off
// R8: reference source: io supply or 3x fixed
// R9: no internal reference disables contrast control
// R10: tie bit in mode B drops reference buffer
// R11: fixed reference enabled automatically when needed
// R12: three bias pins, independent enables, ladder stays
// R13: multiplex field chooses active common lines
// R14: active common overrides its direction bit
// R15: software sets segment enable for segment drive
// R16: segment enable overrides pin direction bit
// R17: after reset all pins are plain I/O; the code keeps COM0 active as an output (multiplex code 0)
// R18: B power field sets ladder power in B
module ladder_pin_ctrl #(
  parameter int unsigned SEG_N = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic lf_clk_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ladder_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] com_dir_i,
  input wire logic [SEG_N-1:0] seg_dir_i,
  output logic [1:0] ladder_power_o,
  output logic ladder_in_b_o,
  output logic [2:0] contrast_tap_select_o,
  output logic contrast_ladder_on_o,
  output logic internal_ref_on_o,
  output logic ref_from_fixed_o,
  output logic fixed_voltage_reference_en_o,
  output logic ref_buffer_on_o,
  output logic [2:0] external_bias_pins_en_o,
  output logic [3:0] common_active_o,
  output logic [3:0] com_dir_o,
  output logic [SEG_N-1:0] segment_drive_o,
  output logic [SEG_N-1:0] seg_dir_o
);
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] ref_r, ref_nxt;
  logic [31:0] tim_r, tim_nxt;
  logic [SEG_N-1:0] segen_r, segen_nxt;
  logic [31:0] rdata_nxt;
  logic ack_nxt;
  logic tick;
  ladder_pkg::phase_t phase_r, phase_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [4:0] slot_len;
  logic [2:0] a_len;
  logic active;
  logic ref_en;
  logic [31:0] wmask;

  tick_sync tick_sync_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(lf_clk_i),
    .rise_o(tick)
  );

  // ---------------- wishbone slave: ack one cycle after request, dropped next cycle
  always_comb begin
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    ctrl_nxt = ctrl_r;
    ref_nxt = ref_r;
    tim_nxt = tim_r;
    segen_nxt = segen_r;
    rdata_nxt = 32'h0000_0000;
    ack_nxt = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    if (ack_nxt) begin
      if (wb_adr_i == ladder_pkg::OFF_CTRL) begin
        rdata_nxt = ctrl_r;
        if (wb_we_i) begin
          ctrl_nxt = ((ctrl_r & ~wmask) | (wb_dat_i & wmask)) & ladder_pkg::CTRL_MASK;
        end
      end else if (wb_adr_i == ladder_pkg::OFF_REF) begin
        rdata_nxt = ref_r;
        if (wb_we_i) begin
          ref_nxt = ((ref_r & ~wmask) | (wb_dat_i & wmask)) & ladder_pkg::REF_MASK;
        end
      end else if (wb_adr_i == ladder_pkg::OFF_TIMING) begin
        rdata_nxt = tim_r;
        if (wb_we_i) begin
          // bit 3 is not stored so it always reads zero (see R4)
          tim_nxt = ((tim_r & ~wmask) | (wb_dat_i & wmask)) & ladder_pkg::TIM_MASK;
        end
      end else if (wb_adr_i == ladder_pkg::OFF_SEGEN) begin
        rdata_nxt = 32'(segen_r);
        if (wb_we_i) begin
          // software writes one to make a pin a segment driver (see R15)
          segen_nxt = SEG_N'(((32'(segen_r) & ~wmask) | (wb_dat_i & wmask)));
        end
      end else begin
        // unmapped offsets read zero and ignore writes, still acknowledged
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= ladder_pkg::CTRL_RST;
      ref_r <= ladder_pkg::REF_RST;
      tim_r <= ladder_pkg::TIM_RST;
      segen_r <= SEG_N'(ladder_pkg::SEGEN_RST); // see R17
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ref_r <= ref_nxt;
      tim_r <= tim_nxt;
      segen_r <= segen_nxt;
      wb_dat_o <= rdata_nxt;
      wb_ack_o <= ack_nxt;
    end
  end

  // ---------------- ladder A/B sequencer, counted in 32 kHz ticks
  always_comb begin
    active = ctrl_r[ladder_pkg::CTRL_ACT_BIT];
    a_len = tim_r[ladder_pkg::TIM_AT_LSB +: 3];
    // type A slot is 15 clocks, type B slot is 31 (see R2) (see R3)
    slot_len = ctrl_r[ladder_pkg::CTRL_WFT_BIT] ? ladder_pkg::SLOT_TYPE_B
                                                 : ladder_pkg::SLOT_TYPE_A;
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    // code 000 gives no A interval: the ladder stays in B for the whole slot
    if (!active) begin
      phase_nxt = ladder_pkg::PH_IDLE;
      cnt_nxt = 5'h00;
    end else if (tick) begin
      if (cnt_r >= slot_len - 5'h01) begin
        cnt_nxt = 5'h00;
      end else begin
        cnt_nxt = cnt_r + 5'h01;
      end
      // first a_len clocks of the slot in A, remainder in B (see R1)
      phase_nxt = ({2'h0, a_len} > cnt_nxt) ? ladder_pkg::PH_A : ladder_pkg::PH_B;
    end else if (phase_r == ladder_pkg::PH_IDLE) begin
      phase_nxt = (a_len != 3'h0) ? ladder_pkg::PH_A : ladder_pkg::PH_B;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= ladder_pkg::PH_IDLE;
      cnt_r <= 5'h00;
    end else begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ---------------- reference, contrast and pin outputs, all registered
  always_comb begin
    ref_en = ref_r[ladder_pkg::REF_EN_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ladder_power_o <= ladder_pkg::PWR_OFF;
      ladder_in_b_o <= 1'b0;
      contrast_tap_select_o <= 3'h0;
      contrast_ladder_on_o <= 1'b0;
      internal_ref_on_o <= 1'b0;
      ref_from_fixed_o <= 1'b0;
      fixed_voltage_reference_en_o <= 1'b0;
      ref_buffer_on_o <= 1'b0;
      external_bias_pins_en_o <= 3'h0;
      common_active_o <= 4'h0;
      com_dir_o <= 4'hf;
      segment_drive_o <= '0;
      seg_dir_o <= '1;
    end else begin
      // B power from its own field, A power from the A field (see R18)
      if (phase_nxt == ladder_pkg::PH_B) begin
        ladder_power_o <= tim_r[ladder_pkg::TIM_BP_LSB +: 2]; // see R18
      end else if (phase_nxt == ladder_pkg::PH_A) begin
        ladder_power_o <= tim_r[ladder_pkg::TIM_AP_LSB +: 2];
      end else begin
        ladder_power_o <= ladder_pkg::PWR_OFF;
      end
      ladder_in_b_o <= (phase_nxt == ladder_pkg::PH_B);
      contrast_tap_select_o <= ref_r[ladder_pkg::REF_CST_LSB +: 3]; // see R5
      // contrast ladder open when inactive or no internal reference (see R6) (see R9)
      contrast_ladder_on_o <= active & ref_en;
      internal_ref_on_o <= active & ref_en; // see R7
      ref_from_fixed_o <= ref_r[ladder_pkg::REF_SRC_BIT]; // see R8
      // fixed reference comes up on its own when the bias needs it (see R11)
      fixed_voltage_reference_en_o <= active & ref_en & ref_r[ladder_pkg::REF_SRC_BIT];
      // buffer dropped in B when tied to the ladder switching (see R10)
      ref_buffer_on_o <= active & ref_en & ref_r[ladder_pkg::REF_SRC_BIT]
                         & ~(ref_r[ladder_pkg::REF_TIE_BIT] & (phase_nxt == ladder_pkg::PH_B));
      // bias pins are independent and leave the ladder untouched (see R12)
      external_bias_pins_en_o <= ref_r[ladder_pkg::REF_PIN_LSB +: 3];
      // static, 1/2, 1/3, 1/4 select commons 0, 0-1, 0-2, 0-3 (see R13)
      case (ctrl_r[ladder_pkg::CTRL_MUX_LSB +: 2])
        2'h0: common_active_o <= 4'h1;
        2'h1: common_active_o <= 4'h3;
        2'h2: common_active_o <= 4'h7;
        default: common_active_o <= 4'hf;
      endcase
      // an active common drives (dir 0 = output) regardless of its direction bit (see R14)
      for (int i = 0; i < 4; i++) begin
        com_dir_o[i] <= (ctrl_r[ladder_pkg::CTRL_MUX_LSB +: 2] >= 2'(i)) ? 1'b0
                        : com_dir_i[i];
      end
      segment_drive_o <= segen_r;
      // segment enable overrides the direction bit (see R16)
      seg_dir_o <= seg_dir_i & ~segen_r;
    end
  end

  // ---------------- assertions
  logic [5:0] a_run_r;
  always_ff @(posedge clk_i) begin
    // a new A-interval code restarts the run, so a shortened code is not blamed on the old run
    if (rst_i || phase_r != ladder_pkg::PH_A || tim_nxt != tim_r) begin
      a_run_r <= 6'h00;
    end else if (tick && a_run_r != 6'h3f) begin
      a_run_r <= a_run_r + 6'h01;
    end
  end

  a_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R1
    a_run_r <= {3'h0, tim_r[2:0]})
    else $error("mode A held longer than the A-interval code");
  slot_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R2
    active && tick && ctrl_nxt == ctrl_r |=> cnt_r < slot_len)
    else $error("slot counter ran past slot length");
  bit3_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R4
    wb_ack_o && $past(wb_adr_i) == ladder_pkg::OFF_TIMING |-> wb_dat_o[3] == 1'b0)
    else $error("timing bit 3 read as one");
  inactive_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R6
    !active ##1 !active |-> !contrast_ladder_on_o && !internal_ref_on_o)
    else $error("ladder or reference on while module inactive");
  tie_buf_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R10
    ref_r[ladder_pkg::REF_TIE_BIT] && phase_nxt == ladder_pkg::PH_B
      && $stable(ref_r) |=> !ref_buffer_on_o)
    else $error("reference buffer on during tied B interval");
  mux_com_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R13
    !rst_i && $stable(ctrl_r)
      |=> common_active_o[0] && (common_active_o[3] == ($past(ctrl_r[1:0]) == 2'h3)))
    else $error("common usage does not match multiplex setting");
  seg_over_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R16
    $stable(segen_r) |=> (seg_dir_o & $past(segen_r)) == '0)
    else $error("segment pin direction not overridden");
  b_power_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R18
    !rst_i && phase_nxt == ladder_pkg::PH_B |=> ladder_power_o == $past(tim_r[5:4]))
    else $error("ladder power does not follow B field");
  reset_io_a: assert property (@(posedge clk_i) // see R17
    rst_i |=> segment_drive_o == '0)
    else $error("segment drive set after reset");

  cov_type_b_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ctrl_r[2] && phase_r == ladder_pkg::PH_A ##1 phase_r == ladder_pkg::PH_B);
  cov_tie_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ref_buffer_on_o ##1 !ref_buffer_on_o);
  cov_quad_c: cover property (@(posedge clk_i) disable iff (rst_i) common_active_o == 4'hf);
endmodule // ladder_pin_ctrl

// ==== lf_osc_model.sv ====
// far-side model: free-running low-frequency oscillator on the 32 kHz pin
`timescale 1ns/1ps
module lf_osc_model #(
  parameter int unsigned HALF_NS = 64
) (
  output logic lf_clk_o
);
  // sped up from 32 kHz so a 31-tick slot stays short, yet far slower than clk_i
  initial begin
    lf_clk_o = 1'b0;
    #3;
    forever begin
      #(HALF_NS);
      lf_clk_o = ~lf_clk_o;
    end
  end
endmodule // lf_osc_model

// ==== lcd_ladder_and_pin_control_bench.sv ====
// self-checking bench for the ladder and pin control block
`timescale 1ns/1ps
module lcd_ladder_and_pin_control_bench;
  localparam int TICK = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic lf_clk_i;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] com_dir_i = 4'hb;
  logic [23:0] seg_dir_i = 24'hf0_f0f0;
  logic [1:0] ladder_power_o;
  logic ladder_in_b_o;
  logic [2:0] contrast_tap_select_o;
  logic contrast_ladder_on_o;
  logic internal_ref_on_o;
  logic ref_from_fixed_o;
  logic fixed_voltage_reference_en_o;
  logic ref_buffer_on_o;
  logic [2:0] external_bias_pins_en_o;
  logic [3:0] common_active_o;
  logic [3:0] com_dir_o;
  logic [23:0] segment_drive_o;
  logic [23:0] seg_dir_o;
  logic [31:0] rd;
  int err_total = 0;
  int samples_checked = 0;

  always #4 clk_i = ~clk_i;

  lf_osc_model #(.HALF_NS(TICK * 4)) lf_osc_model_inst (.lf_clk_o(lf_clk_i));
  ladder_pin_ctrl #(.SEG_N(24)) ladder_pin_ctrl_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lf_clk_i(lf_clk_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .com_dir_i(com_dir_i),
    .seg_dir_i(seg_dir_i),
    .ladder_power_o(ladder_power_o),
    .ladder_in_b_o(ladder_in_b_o),
    .contrast_tap_select_o(contrast_tap_select_o),
    .contrast_ladder_on_o(contrast_ladder_on_o),
    .internal_ref_on_o(internal_ref_on_o),
    .ref_from_fixed_o(ref_from_fixed_o),
    .fixed_voltage_reference_en_o(fixed_voltage_reference_en_o),
    .ref_buffer_on_o(ref_buffer_on_o),
    .external_bias_pins_en_o(external_bias_pins_en_o),
    .common_active_o(common_active_o),
    .com_dir_o(com_dir_o),
    .segment_drive_o(segment_drive_o),
    .seg_dir_o(seg_dir_o)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle; waits for ack, then idles so outputs settle
  task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      err_total++;
      conclude();
    end
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    check(nm, exp, rd);
  endtask

  task automatic wait_b(input logic lvl);
    int k;
    k = 0;
    while (ladder_in_b_o !== lvl && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 2000) begin
      err_total++;
      conclude();
    end
  endtask

  // measures one whole slot after two settling slots; A power is fixed at medium
  task automatic slot(input logic [2:0] n, input logic waveform_type_select, input logic [1:0] bp, input int len);
    int a;
    int b;
    a = 0;
    b = 0;
    xfer(1'b1, ladder_pkg::OFF_CTRL, {28'h0, 1'b1, waveform_type_select, 2'h0});
    xfer(1'b1, ladder_pkg::OFF_TIMING, {24'h0, 2'h2, bp, 1'b0, n});
    repeat (2) begin
      wait_b(1'b1);
      wait_b(1'b0);
    end
    while (ladder_in_b_o === 1'b0 && a < 2000) begin
      @(posedge clk_i);
      a++;
      if (a == 4) begin
        check("power_a", 32'h2, 32'(ladder_power_o));
        check("buf_a", 32'h1, 32'(ref_buffer_on_o));
      end
    end
    while (ladder_in_b_o === 1'b1 && b < 2000) begin
      @(posedge clk_i);
      b++;
      if (b == 4) begin
        check("power_b", 32'(bp), 32'(ladder_power_o));
        check("buf_b", 32'h0, 32'(ref_buffer_on_o));
      end
    end
    check("a_ticks", 32'(n), 32'((a + TICK / 2) / TICK));
    check("b_ticks", 32'(len - n), 32'((b + TICK / 2) / TICK));
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("seg_drv_rst", 32'h0, 32'(segment_drive_o));
    check("seg_dir_rst", 32'h00f0_f0f0, 32'(seg_dir_o));
    rd_chk("ctrl_rst", ladder_pkg::OFF_CTRL, ladder_pkg::CTRL_RST);
    rd_chk("ref_rst", ladder_pkg::OFF_REF, ladder_pkg::REF_RST);
    rd_chk("tim_rst", ladder_pkg::OFF_TIMING, ladder_pkg::TIM_RST);
    rd_chk("segen_rst", ladder_pkg::OFF_SEGEN, ladder_pkg::SEGEN_RST);
    xfer(1'b1, 4'h2, 32'hffff_ffff);
    rd_chk("unmapped", 4'h2, 32'h0);
    xfer(1'b1, ladder_pkg::OFF_TIMING, 32'hffff_ffff);
    rd_chk("tim_bit3", ladder_pkg::OFF_TIMING, 32'h0000_00f7);
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, ladder_pkg::OFF_CTRL, 32'(m));
      check("com_act", 32'((5'h2 << m) - 5'h1), 32'(common_active_o));
      check("com_dir", 32'(com_dir_i & ~4'((5'h2 << m) - 5'h1)), 32'(com_dir_o));
    end
    xfer(1'b1, ladder_pkg::OFF_SEGEN, 32'h00a5_0f3c);
    check("seg_drv", 32'h00a5_0f3c, 32'(segment_drive_o));
    check("seg_dir", 32'h0050_f0c0, 32'(seg_dir_o));
    // reset in mid-run must hand every segment pin back to plain I/O
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("seg_drv_rst2", 32'h0, 32'(segment_drive_o));
    check("seg_dir_rst2", 32'h00f0_f0f0, 32'(seg_dir_o));
    xfer(1'b1, ladder_pkg::OFF_CTRL, 32'h0);
    xfer(1'b1, ladder_pkg::OFF_REF, 32'h0000_01eb);
    check("ladder_off", 32'h0, 32'(contrast_ladder_on_o));
    check("iref_off", 32'h0, 32'(internal_ref_on_o));
    check("tap", 32'h7, 32'(contrast_tap_select_o));
    check("vpins", 32'h5, 32'(external_bias_pins_en_o));
    xfer(1'b1, ladder_pkg::OFF_CTRL, 32'h8);
    check("ladder_on", 32'h1, 32'(contrast_ladder_on_o));
    check("iref_on", 32'h1, 32'(internal_ref_on_o));
    check("fvr_auto", 32'h1, 32'(fixed_voltage_reference_en_o));
    check("src_fixed", 32'h1, 32'(ref_from_fixed_o));
    xfer(1'b1, ladder_pkg::OFF_REF, 32'h0000_01e9);
    check("src_io", 32'h0, 32'(ref_from_fixed_o));
    check("fvr_idle", 32'h0, 32'(fixed_voltage_reference_en_o));
    xfer(1'b1, ladder_pkg::OFF_REF, 32'h0000_01e8);
    check("no_iref", 32'h0, 32'(contrast_ladder_on_o));
    check("no_iref_src", 32'h0, 32'(internal_ref_on_o));
    rd_chk("ref_rb", ladder_pkg::OFF_REF, 32'h0000_01e8);
    xfer(1'b1, ladder_pkg::OFF_REF, 32'h0000_0007);
    slot(3'h1, 1'b0, 2'h1, 15);
    slot(3'h5, 1'b0, 2'h2, 15);
    slot(3'h1, 1'b1, 2'h0, 31);
    slot(3'h5, 1'b1, 2'h1, 31);
    // without the tie bit the buffer must stay on through interval B
    xfer(1'b1, ladder_pkg::OFF_REF, 32'h0000_0003);
    wait_b(1'b1);
    repeat (2) @(posedge clk_i);
    check("buf_untied", 32'h1, 32'(ref_buffer_on_o));
    conclude();
  end
endmodule // lcd_ladder_and_pin_control_bench
